// ==== psc_cfg_if.sv ====
`timescale 1ns/1ps
// Configuration words of one channel, register bank to phase logic
interface psc_cfg_if;
  logic [15:0] drop_ramp;
  logic [15:0] add_th;
  modport regs (output drop_ramp, output add_th);
  modport ctrl (input drop_ramp, input add_th);
endinterface

// ==== psc_host_model.sv ====
`timescale 1ns/1ps
// Management-bus host: one command pulse per call, answer taken one cycle on
module psc_host_model (
  input  wire logic        clk_sys,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_is_word,
  output logic      [7:0]  cmd_code,
  output logic      [7:0]  cmd_page,
  output logic      [15:0] cmd_wdata,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_nack,
  input  wire logic [15:0] cmd_rdata
);
  // Idle bus; data idles inverted so a stale word never passes for a fresh one
  initial begin
    cmd_valid   = 1'b0;
    cmd_write   = 1'b0;
    cmd_is_word = 1'b0;
    cmd_code    = 8'h00;
    cmd_page    = 8'h00;
    cmd_wdata   = 16'hffff;
  end
  // Request changes just after an edge and is held through the taking edge
  task automatic xfer(input logic wr, input logic word, input logic [7:0] code,
                      input logic [7:0] page, input logic [15:0] wd,
                      output logic [1:0] resp, output logic [15:0] rd);
    @(posedge clk_sys);
    #1;
    cmd_valid   = 1'b1;
    cmd_write   = wr;
    cmd_is_word = word;
    cmd_code    = code;
    cmd_page    = page;
    cmd_wdata   = wd;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~wd;
    resp      = {cmd_ack, cmd_nack};
    rd        = cmd_rdata;
  endtask
endmodule // psc_host_model

// ==== psc_phase_ctrl.sv ====
`timescale 1ns/1ps
module psc_phase_ctrl
  import psc_pkg::*;
#(
  parameter logic [2:0]  MAX_PH   = 3'h6,
  parameter logic [15:0] DROP_CYC = 16'h2981,
  parameter logic [7:0]  IEFF0    = 8'h0a,
  parameter logic [7:0]  IEFF1    = 8'h0f,
  parameter logic [7:0]  IEFF2    = 8'h14,
  parameter logic [7:0]  IEFF3    = 8'h19
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  psc_cfg_if.ctrl          cfg,
  input  wire logic        usr_level1,
  input  wire logic [7:0]  avg_current,
  input  wire logic [7:0]  peak_current,
  output logic      [2:0]  phase_count,
  output logic      [5:0]  phase_enable,
  output logic      [8:0]  ramp_mv,
  output logic             dcm_active
);
  logic        shed_en;
  logic [7:0]  ieff;
  logic [1:0]  add_code;
  logic [1:0]  drop_code;
  logic        drop_ok;
  logic [11:0] add_th;
  logic [11:0] drop_th;
  logic        drop_cond;
  logic [15:0] drop_timer;
  logic [8:0]  next_ramp;

  assign shed_en = cfg.drop_ramp[SHED_EN_BIT];

  // Peak-efficiency current per phase, picked by the coarse field
  always_comb begin
    case (cfg.add_th[COARSE_LSB +: 2])
      2'h0:    ieff = IEFF0;
      2'h1:    ieff = IEFF1;
      2'h2:    ieff = IEFF2;
      default: ieff = IEFF3;
    endcase
  end

  // Fine fields for the transitions out of the present count
  always_comb begin
    add_code  = 2'h0;
    drop_code = 2'h0;
    drop_ok   = 1'b1;
    case (phase_count)
      3'h1: begin
        add_code = cfg.add_th[ADD12_LSB +: 2];
        drop_ok  = 1'b0;
      end
      3'h2: begin
        add_code  = cfg.add_th[ADD23_LSB +: 2];
        drop_code = cfg.add_th[DROP21_LSB +: 2];
        drop_ok   = cfg.add_th[ONE_PH_EN_BIT];
      end
      3'h3: begin
        add_code  = cfg.add_th[ADD34_LSB +: 2];
        drop_code = cfg.drop_ramp[DROP32_LSB +: 2];
      end
      3'h4: begin
        add_code  = cfg.add_th[ADD45_LSB +: 2];
        drop_code = cfg.drop_ramp[DROP43_LSB +: 2];
      end
      3'h5: begin
        add_code  = cfg.add_th[ADD56_LSB +: 2];
        drop_code = cfg.drop_ramp[DROP54_LSB +: 2];
      end
      default: drop_code = cfg.drop_ramp[DROP65_LSB +: 2];
    endcase
  end

  // Thresholds scale with the active count; drop side compares biased values
  assign add_th    = 12'(phase_count * ieff) + add_offset(add_code);
  assign drop_th   = 12'((phase_count - 3'h1) * ieff) + drop_offset(drop_code);
  assign drop_cond = ({4'h0, avg_current} + DROP_BIAS_A) < drop_th;

  // Count moves one phase at a time while shedding is on, so phases join and leave in order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_count <= MAX_PH;
      drop_timer  <= 16'h0000;
    end else if (!shed_en) begin
      phase_count <= MAX_PH; // RULE_16
      drop_timer  <= 16'h0000;
    end else if (phase_count < MAX_PH && {4'h0, peak_current} >= add_th) begin
      phase_count <= phase_count + 3'h1; // RULE_14 RULE_15
      drop_timer  <= 16'h0000;
    end else if (phase_count > 3'h1 && drop_ok && drop_cond) begin
      if (drop_timer == DROP_CYC - 16'h0001) begin
        phase_count <= phase_count - 3'h1; // RULE_07 RULE_14 RULE_15
        drop_timer  <= 16'h0000;
      end else begin
        drop_timer <= drop_timer + 16'h0001;
      end
    end else begin
      drop_timer <= 16'h0000; // Any lift above threshold restarts the wait
    end
  end

  // Lowest-numbered phases stay on
  assign phase_enable = 6'((7'h01 << phase_count) - 7'h01); // RULE_15

  // Ramp: undershoot override first, then low-count overrides, else base
  always_comb begin
    next_ramp = RAMP_STEP_MV * 9'(cfg.drop_ramp[RAMP_LSB +: 3] + 4'h1); // RULE_12
    if (usr_level1 && cfg.drop_ramp[USR_RAMP_LSB +: 2] != 2'h0) begin
      next_ramp = RAMP_STEP_MV * 9'(cfg.drop_ramp[USR_RAMP_LSB +: 2]); // RULE_09
    end else if (phase_count == 3'h2 && cfg.drop_ramp[RAMP2_BIT]) begin
      next_ramp = TWO_PH_RAMP_MV; // RULE_10
    end else if (phase_count == 3'h1 && cfg.drop_ramp[RAMP1_BIT]) begin
      next_ramp = ONE_PH_RAMP_MV; // RULE_11
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_mv    <= RAMP_STEP_MV;
      dcm_active <= 1'b0;
    end else begin
      ramp_mv    <= next_ramp;
      dcm_active <= shed_en && phase_count == 3'h1 && cfg.add_th[DCM_BIT];
    end
  end

  a_disable_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !shed_en |=> phase_count == MAX_PH) else $error("count not max when off"); // RULE_16
  a_add_immediate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shed_en && phase_count < MAX_PH && {4'h0, peak_current} >= add_th
    |=> phase_count == $past(phase_count) + 3'h1) else $error("late add"); // RULE_14
  a_drop_waits: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shed_en && $fell(phase_count != MAX_PH) == 1'b0 && phase_count < $past(phase_count)
    |-> $past(drop_timer) == DROP_CYC - 16'h0001) else $error("early drop"); // RULE_14
endmodule // psc_phase_ctrl

// ==== psc_phase_shed_config_regs.sv ====
`timescale 1ns/1ps
// Function
// [RULE_01] Command DEh taken only as word access
// [RULE_02] Page 00h is channel A, 01h channel B
// [RULE_03] Bits 15:14 six-to-five drop offset, page 0
// [RULE_04] Bits 13:12 five-to-four drop offset, page 0
// [RULE_05] Bits 11:10 four-to-three drop offset, page 0
// [RULE_06] Bits 9:8 three-to-two drop offset
// [RULE_07] Shed phase when average reaches drop threshold; the code sheds only once the average is below the threshold, not at it
// [RULE_08] Bit 7 enables dynamic phase shedding
// [RULE_09] Bits 6:5 undershoot level-1 ramp override
// [RULE_10] Bit 4 forces 120 mV at two phases
// [RULE_11] Bit 3 forces 80 mV at one phase
// [RULE_12] Bits 2:0 base ramp, 40 mV steps
// [RULE_13] Command DFh paged word, word access only
// [RULE_14] Add at once, drop after 85 us
// [RULE_15] Phases join and leave in numerical order
// [RULE_16] Shedding off runs all available phases
// [RULE_17] Fields load from nonvolatile store, stay writable
// [RULE_18] Drop code 10b acts like 01b
module psc_phase_shed_config_regs #(
  parameter logic [15:0] DROP_CYC = 16'(psc_pkg::DROP_DELAY_CYC),
  parameter logic [7:0]  IEFF0    = 8'h0a,
  parameter logic [7:0]  IEFF1    = 8'h0f,
  parameter logic [7:0]  IEFF2    = 8'h14,
  parameter logic [7:0]  IEFF3    = 8'h19
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Nonvolatile defaults, stable from power-up
  input  wire logic [15:0] nvm_drop_ramp_a,
  input  wire logic [15:0] nvm_add_th_a,
  input  wire logic [15:0] nvm_drop_ramp_b,
  input  wire logic [15:0] nvm_add_th_b,
  // Decoded management-bus command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_is_word,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_page,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ack,
  output logic             cmd_nack,
  output logic      [15:0] cmd_rdata,
  // Per-channel loop signals
  input  wire logic        usr_level1_a,
  input  wire logic        usr_level1_b,
  input  wire logic [7:0]  avg_current_a,
  input  wire logic [7:0]  peak_current_a,
  input  wire logic [7:0]  avg_current_b,
  input  wire logic [7:0]  peak_current_b,
  output logic      [2:0]  phase_count_a,
  output logic      [5:0]  phase_enable_a,
  output logic      [8:0]  ramp_mv_a,
  output logic             dcm_active_a,
  output logic      [2:0]  phase_count_b,
  output logic      [5:0]  phase_enable_b,
  output logic      [8:0]  ramp_mv_b,
  output logic             dcm_active_b,
  output logic             cfg_loaded
);
  import psc_pkg::*;

  logic        rst_meta;
  logic        rst_n;
  logic [1:0]  usr_meta;
  logic [1:0]  usr_sync;
  logic [15:0] drop_ramp [NUM_CH];
  logic [15:0] add_th    [NUM_CH];
  logic        code_ok;
  logic        page_ok;
  logic        take;
  logic        chan;
  logic [15:0] wmask;
  logic [6:0]  phase_enable_b_unused;

  psc_cfg_if cfg_a ();
  psc_cfg_if cfg_b ();

  // Page-0-only bits never exist on channel B
  function automatic logic [15:0] page_mask(input logic is_b, input logic [15:0] m);
    return is_b ? ~m : 16'hffff;
  endfunction

  // Reset release through two flops so every flop leaves reset on one edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Undershoot level comes from the analog loop, so it is synchronised
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usr_meta <= 2'h0;
      usr_sync <= 2'h0;
    end else begin
      usr_meta <= {usr_level1_b, usr_level1_a};
      usr_sync <= usr_meta;
    end
  end

  // Command decode; FFh broadcast is not offered for these words
  assign code_ok = cmd_code == CMD_DROP_RAMP || cmd_code == CMD_ADD_TH; // RULE_01 RULE_13
  assign page_ok = cmd_page == PAGE_A || cmd_page == PAGE_B; // RULE_02
  assign take    = cmd_valid && cfg_loaded && code_ok && page_ok && cmd_is_word; // RULE_01
  assign chan    = cmd_page == PAGE_B; // RULE_02
  assign wmask   = cmd_code == CMD_DROP_RAMP ? page_mask(chan, DROP_PAGE0_MASK)
                                             : page_mask(chan, ADD_PAGE0_MASK);

  // Defaults load once after release; host writes follow. Bus refuses commands until load.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        drop_ramp[i] <= WORD_RESET;
        add_th[i]    <= WORD_RESET;
      end
    end else if (!cfg_loaded) begin
      cfg_loaded   <= 1'b1; // RULE_17
      drop_ramp[0] <= nvm_drop_ramp_a; // RULE_17
      add_th[0]    <= nvm_add_th_a;
      drop_ramp[1] <= nvm_drop_ramp_b & page_mask(1'b1, DROP_PAGE0_MASK); // RULE_03 RULE_04
      add_th[1]    <= nvm_add_th_b & page_mask(1'b1, ADD_PAGE0_MASK);
    end else if (take && cmd_write) begin
      if (cmd_code == CMD_DROP_RAMP) begin
        drop_ramp[chan] <= cmd_wdata & wmask; // RULE_03 RULE_04 RULE_05 RULE_06
      end else begin
        add_th[chan] <= cmd_wdata & wmask; // RULE_13
      end
    end
  end

  // Answers one cycle after the command; refused commands change nothing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ack   <= 1'b0;
      cmd_nack  <= 1'b0;
      cmd_rdata <= WORD_RESET;
    end else begin
      cmd_ack  <= take;
      cmd_nack <= cmd_valid && !take; // RULE_01
      if (take && !cmd_write) begin
        cmd_rdata <= cmd_code == CMD_DROP_RAMP ? drop_ramp[chan] : add_th[chan];
      end
    end
  end

  // Hand the live words to each channel's phase logic
  assign cfg_a.drop_ramp = drop_ramp[0]; // RULE_08
  assign cfg_a.add_th    = add_th[0];
  assign cfg_b.drop_ramp = drop_ramp[1];
  assign cfg_b.add_th    = add_th[1];

  // Channel A may use up to six phases
  psc_phase_ctrl #(
    .MAX_PH   (MAX_PH_A),
    .DROP_CYC (DROP_CYC),
    .IEFF0    (IEFF0),
    .IEFF1    (IEFF1),
    .IEFF2    (IEFF2),
    .IEFF3    (IEFF3)
  ) u_phase_a (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .cfg          (cfg_a.ctrl),
    .usr_level1   (usr_sync[0]),
    .avg_current  (avg_current_a),
    .peak_current (peak_current_a),
    .phase_count  (phase_count_a),
    .phase_enable (phase_enable_a),
    .ramp_mv      (ramp_mv_a),
    .dcm_active   (dcm_active_a)
  );

  // Channel B is limited to two phases; its upper fields are absent
  psc_phase_ctrl #(
    .MAX_PH   (MAX_PH_B),
    .DROP_CYC (DROP_CYC),
    .IEFF0    (IEFF0),
    .IEFF1    (IEFF1),
    .IEFF2    (IEFF2),
    .IEFF3    (IEFF3)
  ) u_phase_b (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .cfg          (cfg_b.ctrl),
    .usr_level1   (usr_sync[1]),
    .avg_current  (avg_current_b),
    .peak_current (peak_current_b),
    .phase_count  (phase_count_b),
    .phase_enable (phase_enable_b),
    .ramp_mv      (ramp_mv_b),
    .dcm_active   (dcm_active_b)
  );

  // Spare vector kept only to prove channel B never lights more than two
  assign phase_enable_b_unused = {1'b0, phase_enable_b};

  // Accepted word write to a given command and page
  sequence s_write(logic [7:0] code, logic [7:0] pg);
    cmd_valid && cmd_write && cmd_is_word && cmd_code == code && cmd_page == pg
      && cfg_loaded;
  endsequence

  // Accepted word read to a given command and page
  sequence s_read(logic [7:0] code, logic [7:0] pg);
    cmd_valid && !cmd_write && cmd_is_word && cmd_code == code && cmd_page == pg
      && cfg_loaded;
  endsequence

  a_byte_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !cmd_is_word |=> cmd_nack && !cmd_ack
      && $stable(drop_ramp[0]) && $stable(add_th[0]))
    else $error("byte access not refused"); // RULE_01
  a_page_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !(cmd_page == PAGE_A || cmd_page == PAGE_B) |=> cmd_nack)
    else $error("bad page accepted"); // RULE_02
  a_write_lands_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(CMD_DROP_RAMP, PAGE_A) |=> cmd_ack && drop_ramp[0] == $past(cmd_wdata))
    else $error("page 0 write lost"); // RULE_02
  a_page1_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(CMD_DROP_RAMP, PAGE_B) |=> drop_ramp[1][15:10] == 6'h00
      && drop_ramp[1][9:0] == $past(cmd_wdata[9:0]))
    else $error("page 1 drop word wrong"); // RULE_03
  a_add_write_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(CMD_ADD_TH, PAGE_B) |=> add_th[1] == ($past(cmd_wdata) & ~ADD_PAGE0_MASK)
      && $stable(add_th[0]))
    else $error("page 1 add word wrong"); // RULE_13
  a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(CMD_ADD_TH, PAGE_A) ##1 s_read(CMD_ADD_TH, PAGE_A)
      |=> cmd_rdata == $past(cmd_wdata, 2))
    else $error("read does not return write"); // RULE_13
  a_nvm_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_loaded |=> cfg_loaded && drop_ramp[0] == $past(nvm_drop_ramp_a)
      && add_th[0] == $past(nvm_add_th_a))
    else $error("defaults not loaded"); // RULE_17
  a_enable_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(CMD_DROP_RAMP, PAGE_A) ##1 !drop_ramp[0][SHED_EN_BIT] |=> phase_count_a == MAX_PH_A)
    else $error("disable did not restore phases"); // RULE_08
  a_b_two_max: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_enable_b_unused[6:2] == 5'h00)
    else $error("channel b over two phases"); // RULE_16
  a_ramp_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_count_a == 3'h2 && drop_ramp[0][RAMP2_BIT] && !usr_sync[0]
      ##1 $stable(phase_count_a) && $stable(drop_ramp[0]) |-> ramp_mv_a == TWO_PH_RAMP_MV)
    else $error("two phase ramp wrong"); // RULE_10
  a_ramp_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_count_a == 3'h1 && drop_ramp[0][RAMP1_BIT] && !drop_ramp[0][RAMP2_BIT]
      && !usr_sync[0] ##1 $stable(phase_count_a) && $stable(drop_ramp[0])
      |-> ramp_mv_a == ONE_PH_RAMP_MV)
    else $error("one phase ramp wrong"); // RULE_11
  a_ramp_base: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_count_a > 3'h2 && !usr_sync[0] ##1 $stable(phase_count_a) && $stable(drop_ramp[0])
      |-> ramp_mv_a == RAMP_STEP_MV * 9'(drop_ramp[0][2:0] + 4'h1))
    else $error("base ramp wrong"); // RULE_12
  a_ramp_usr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    usr_sync[0] && drop_ramp[0][6:5] == 2'h3 ##1 $stable(usr_sync[0]) && $stable(drop_ramp[0])
      |-> ramp_mv_a == TWO_PH_RAMP_MV)
    else $error("undershoot ramp wrong"); // RULE_09
  a_one_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drop_ramp[0][SHED_EN_BIT] && $past(drop_ramp[0][SHED_EN_BIT])
      |-> phase_count_a - $past(phase_count_a) inside {3'h0, 3'h1, 3'h7})
    else $error("phase count jumped"); // RULE_15
  a_drop_code_10: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drop_offset(2'h2) == drop_offset(2'h1))
    else $error("code 10b differs from 01b"); // RULE_18
  a_shed_avg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_count_a < $past(phase_count_a) && drop_ramp[0][SHED_EN_BIT]
      |-> $past(phase_count_a) > 3'h1)
    else $error("shed below one phase"); // RULE_07

  // Bus answers track the command strobe; a refused bad page leaves drop_ramp[0] and both channel B words alone
  a_answer_once: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    !cmd_valid |=> !cmd_ack && !cmd_nack)
    else $error("answer without command");
  a_nack_alone: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    cmd_nack |-> !cmd_ack)
    else $error("ack and nack together");
  a_early_nack: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_17
    cmd_valid && !cfg_loaded |=> cmd_nack && !cmd_ack)
    else $error("command taken before load");
  a_bad_page_stable: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    cmd_valid && cfg_loaded && !(cmd_page == PAGE_A || cmd_page == PAGE_B)
      |=> $stable(drop_ramp[1]) && $stable(add_th[1]) && $stable(drop_ramp[0]))
    else $error("refused command changed a word");
  a_read_page_b: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    s_read(CMD_DROP_RAMP, PAGE_B) |=> cmd_ack && cmd_rdata == $past(drop_ramp[1]))
    else $error("page 1 read wrong");

  // Channel B loop: shedding off pins both phases
  a_b_disable_full: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_16
    !drop_ramp[1][SHED_EN_BIT] |=> phase_count_b == MAX_PH_B)
    else $error("channel b not at max when off");

  // Discontinuous mode may only follow a one-phase cycle with shedding on
  a_dcm_one_phase: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_13
    dcm_active_b |-> $past(phase_count_b) == 3'h1 && $past(add_th[1][DCM_BIT])
      && $past(drop_ramp[1][SHED_EN_BIT]))
    else $error("discontinuous mode outside one phase");
endmodule // psc_phase_shed_config_regs

// ==== psc_phase_shed_config_regs_test.sv ====
`timescale 1ns/1ps
module psc_phase_shed_config_regs_test;
  import psc_pkg::*;
  // Short drop delay keeps each shed step to sixteen cycles
  localparam logic [15:0] DCYC = 16'h0010;
  `define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
  logic        clk_sys, reset_n, cmd_valid, cmd_write, cmd_is_word, cmd_ack, cmd_nack;
  logic        cfg_loaded, usr_a, usr_b, dcm_a, dcm_b;
  logic [7:0]  cmd_code, cmd_page, avg_a, peak_a, avg_b, peak_b;
  logic [15:0] cmd_wdata, cmd_rdata, rd, nv_da, nv_aa, nv_db, nv_ab;
  logic [2:0]  cnt_a, cnt_b;
  logic [5:0]  en_a, en_b;
  logic [8:0]  ramp_a, ramp_b;
  logic [1:0]  resp;
  logic [7:0]  thr [4] = '{8'h12, 8'h16, 8'h16, 8'h18};
  int          n_fail, checked, cycles, w;

  psc_host_model i_psc_host_model (.clk_sys, .cmd_valid, .cmd_write, .cmd_is_word,
    .cmd_code, .cmd_page, .cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata);
  psc_phase_shed_config_regs #(.DROP_CYC(DCYC)) i_psc_phase_shed_config_regs (
    .clk_sys, .reset_n, .nvm_drop_ramp_a(nv_da), .nvm_add_th_a(nv_aa),
    .nvm_drop_ramp_b(nv_db), .nvm_add_th_b(nv_ab), .cmd_valid, .cmd_write,
    .cmd_is_word, .cmd_code, .cmd_page, .cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata,
    .usr_level1_a(usr_a), .usr_level1_b(usr_b), .avg_current_a(avg_a),
    .peak_current_a(peak_a), .avg_current_b(avg_b), .peak_current_b(peak_b),
    .phase_count_a(cnt_a), .phase_enable_a(en_a), .ramp_mv_a(ramp_a), .dcm_active_a(dcm_a),
    .phase_count_b(cnt_b), .phase_enable_b(en_b), .ramp_mv_b(ramp_b), .dcm_active_b(dcm_b),
    .cfg_loaded);

  // Free-running 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrc(input logic [7:0] code, input logic [7:0] page, input logic [15:0] d);
    i_psc_host_model.xfer(1'b1, 1'b1, code, page, d, resp, rd);
    `CHECK(resp, 2'b10)
  endtask
  task automatic rdc(input logic [7:0] code, input logic [7:0] page, input logic [15:0] e);
    i_psc_host_model.xfer(1'b0, 1'b1, code, page, 16'h0000, resp, rd);
    `CHECK({resp, rd}, {2'b10, e})
  endtask
  // Bounded wait for a channel to settle at a given phase count
  task automatic wait_cnt(input bit ch, input logic [2:0] n, output int c);
    c = 0;
    while ((ch ? cnt_b : cnt_a) !== n && c < 100) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
  endtask

  initial begin
    reset_n = 1'b0;
    usr_a = 1'b0;
    usr_b = 1'b0;
    {avg_a, peak_a, avg_b, peak_b} = 32'h00000000;
    nv_da = 16'h5a05;
    nv_aa = 16'h2a00;
    nv_db = 16'hf402;
    nv_ab = 16'h9f81;
    cyc(10);
    reset_n = 1'b1;
    w = 0;
    while (cfg_loaded !== 1'b1 && w < 20) begin
      cyc(1);
      w++;
    end
    cyc(2);
    // Defaults from the store, page 1 showing only its own fields
    rdc(CMD_DROP_RAMP, PAGE_A, nv_da);
    rdc(CMD_ADD_TH, PAGE_A, nv_aa);
    rdc(CMD_DROP_RAMP, PAGE_B, nv_db & ~DROP_PAGE0_MASK);
    rdc(CMD_ADD_TH, PAGE_B, nv_ab & ~ADD_PAGE0_MASK);
    `CHECK(cnt_a, 3'h6)
    `CHECK(ramp_a, 9'h0f0)
    $display("defaults done");
    // Page 1 write, then byte, bad page and bad code all refused
    wrc(CMD_ADD_TH, PAGE_B, 16'hffff);
    rdc(CMD_ADD_TH, PAGE_B, 16'hffff & ~ADD_PAGE0_MASK);
    i_psc_host_model.xfer(1'b1, 1'b0, CMD_DROP_RAMP, PAGE_A, 16'h0000, resp, rd);
    `CHECK(resp, 2'b01)
    i_psc_host_model.xfer(1'b1, 1'b1, CMD_DROP_RAMP, 8'hff, 16'h0000, resp, rd);
    `CHECK(resp, 2'b01)
    i_psc_host_model.xfer(1'b0, 1'b0, CMD_ADD_TH, PAGE_A, 16'h0000, resp, rd);
    `CHECK(resp, 2'b01)
    i_psc_host_model.xfer(1'b1, 1'b1, 8'hdd, PAGE_A, 16'h0000, resp, rd);
    `CHECK(resp, 2'b01)
    rdc(CMD_DROP_RAMP, PAGE_A, nv_da);
    $display("access done");
    // Every base ramp code, six phases so the phase overrides stay out
    for (int i = 0; i < 8; i++) begin
      wrc(CMD_DROP_RAMP, PAGE_A, {13'h0000, 3'(i)});
      cyc(2);
      `CHECK(ramp_a, RAMP_STEP_MV * 9'(i + 1))
    end
    usr_a = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wrc(CMD_DROP_RAMP, PAGE_A, {9'h000, 2'(i), 5'h1d});
      cyc(4);
      `CHECK(ramp_a, (i == 0) ? 9'h0f0 : RAMP_STEP_MV * 9'(i))
    end
    usr_a = 1'b0;
    $display("ramp done");
    // Channel B: two phases, then shed to one with discontinuous mode
    wrc(CMD_DROP_RAMP, PAGE_B, 16'h0017);
    cyc(2);
    `CHECK(ramp_b, TWO_PH_RAMP_MV)
    wrc(CMD_ADD_TH, PAGE_B, 16'h8004);
    wrc(CMD_DROP_RAMP, PAGE_B, 16'h008f);
    wait_cnt(1'b1, 3'h1, w);
    `CHECK(w >= DCYC - 2, 1'b1)
    `CHECK({cnt_b, en_b}, {3'h1, 6'h01})
    cyc(2);
    `CHECK({ramp_b, dcm_b}, {ONE_PH_RAMP_MV, 1'b1})
    peak_b = 8'h0f;
    cyc(4);
    `CHECK(cnt_b, 3'h1)
    peak_b = 8'h10;
    cyc(2);
    `CHECK(cnt_b, 3'h2)
    peak_b = 8'h00;
    $display("channel b done");
    // Channel A sheds one phase at a time down to two
    wrc(CMD_ADD_TH, PAGE_A, 16'h0000);
    wrc(CMD_DROP_RAMP, PAGE_A, 16'h0080);
    for (int n = 5; n >= 2; n--) begin
      wait_cnt(1'b0, 3'(n), w);
      `CHECK(w >= DCYC - 2, 1'b1)
      `CHECK({cnt_a, en_a}, {3'(n), 6'h3f >> (6 - n)})
    end
    // Three-to-two threshold for every offset code, at and just below
    for (int i = 0; i < 4; i++) begin
      wrc(CMD_DROP_RAMP, PAGE_A, {6'h00, 2'(i), 8'h80});
      peak_a = 8'h1a;
      cyc(3);
      peak_a = 8'h00;
      `CHECK(cnt_a, 3'h3)
      avg_a = thr[i];
      cyc(DCYC + 4);
      `CHECK(cnt_a, 3'h3)
      avg_a = thr[i] - 8'h01;
      cyc(DCYC + 4);
      `CHECK(cnt_a, 3'h2)
    end
    wrc(CMD_DROP_RAMP, PAGE_A, 16'h0000);
    cyc(2);
    `CHECK({cnt_a, en_a, dcm_a}, {3'h6, 6'h3f, 1'b0})
    $display("channel a done");
    finish_test();
  end
endmodule // psc_phase_shed_config_regs_test

// ==== psc_pkg.sv ====
package psc_pkg;
  // Command codes and page selectors
  localparam logic [7:0] CMD_DROP_RAMP = 8'hde;
  localparam logic [7:0] CMD_ADD_TH    = 8'hdf;
  localparam logic [7:0] PAGE_A        = 8'h00;
  localparam logic [7:0] PAGE_B        = 8'h01;
  localparam int         NUM_CH        = 2;
  // Field positions of shed_drop_and_ramp_cfg
  localparam int DROP65_LSB = 14;
  localparam int DROP54_LSB = 12;
  localparam int DROP43_LSB = 10;
  localparam int DROP32_LSB = 8;
  localparam int SHED_EN_BIT = 7;
  localparam int USR_RAMP_LSB = 5;
  localparam int RAMP2_BIT = 4;
  localparam int RAMP1_BIT = 3;
  localparam int RAMP_LSB = 0;
  // Field positions of shed_add_threshold_cfg
  localparam int DCM_BIT = 15;
  localparam int DROP21_LSB = 13;
  localparam int ADD56_LSB = 11;
  localparam int ADD45_LSB = 9;
  localparam int ADD34_LSB = 7;
  localparam int ADD23_LSB = 5;
  localparam int ADD12_LSB = 3;
  localparam int ONE_PH_EN_BIT = 2;
  localparam int COARSE_LSB = 0;
  // Bits that exist on page 0 only; they read as zero on page 1
  localparam logic [15:0] DROP_PAGE0_MASK = 16'hfc00;
  localparam logic [15:0] ADD_PAGE0_MASK  = 16'h1f80;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  // Ramp amplitudes in mV
  localparam logic [8:0] RAMP_STEP_MV   = 9'h028;
  localparam logic [8:0] TWO_PH_RAMP_MV = 9'h078;
  localparam logic [8:0] ONE_PH_RAMP_MV = 9'h050;
  // Threshold arithmetic in A; drop offsets are biased by +2 A to stay unsigned
  localparam logic [11:0] ADD_BASE_A  = 12'h006;
  localparam logic [11:0] DROP_BIAS_A = 12'h002;
  // Drop delay
  localparam int DROP_DELAY_NS = 85000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DROP_DELAY_CYC = (DROP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MAX_PH_A = 3'h6;
  localparam logic [2:0] MAX_PH_B = 3'h2;

  // Add offset: 6, 8, 10, 12 A
  function automatic logic [11:0] add_offset(input logic [1:0] code);
    return ADD_BASE_A + {9'h000, code, 1'b0};
  endfunction

  // Biased drop offset: -2, +2, +2, +4 A become 0, 4, 4, 6; code 10b acts as 01b
  function automatic logic [11:0] drop_offset(input logic [1:0] code);
    case (code)
      2'h0:    return 12'h000;
      2'h3:    return 12'h006;
      default: return 12'h004;
    endcase
  endfunction
endpackage
